// >>> src/psr_dev.sv
`timescale 1ns/100ps
module psr_dev
  import psr_pkg::*;
(
  // system
  input  wire logic        clk,
  input  wire logic        resetn,
  // link
  psr_link_if.dev          lnk,
  // sensor core
  input  wire logic        vdd_ok,
  input  wire logic        mem_fail,
  input  wire logic        meas_done,
  input  wire logic [23:0] meas_word,
  input  wire logic        meas_sat,
  output logic             meas_start,
  output logic             operating
);

  typedef struct packed {
    logic [1:0]  scl_s;
    logic [1:0]  sda_s;
    logic [1:0]  sclk_s;
    logic [1:0]  mosi_s;
    logic [1:0]  ss_s;
    logic        scl_p;
    logic        sda_p;
    logic        sclk_p;
    logic        ss_p;
    psr_pwr_t    pwr;
    logic        memf;
    logic        sat;
    logic [23:0] press;
    psr_i2c_t    ist;
    logic [3:0]  icnt;
    logic [7:0]  ish;
    logic [2:0]  ibyte;
    logic        iack;
    logic        sda_oe;
    logic [23:0] cmd;
    logic [1:0]  cmd_n;
    logic [31:0] stx;
    logic [2:0]  sbit;
    logic        miso;
    logic        meas_start;
  } psr_dev_st_t;

  psr_dev_st_t q;
  psr_dev_st_t d;
  logic        scl;
  logic        sda;
  logic        sclk;
  logic        ss;
  logic        scl_r;
  logic        scl_f;
  logic        i2c_start;
  logic        i2c_stop;
  logic        sclk_r;
  logic        sclk_f;
  logic        ss_f;
  logic        ss_r;
  logic        fire;
  logic [7:0]  status;
  logic [31:0] word;
  logic [7:0]  nxt_byte;

  // only the second sync stage is ever looked at
  assign scl       = q.scl_s[1];
  assign sda       = q.sda_s[1];
  assign sclk      = q.sclk_s[1];
  assign ss        = ~q.ss_s[1];
  assign scl_r     = scl & ~q.scl_p;
  assign scl_f     = ~scl & q.scl_p;
  assign i2c_start = scl & q.scl_p & q.sda_p & ~sda;
  assign i2c_stop  = scl & q.scl_p & ~q.sda_p & sda;
  assign sclk_r    = sclk & ~q.sclk_p;
  assign sclk_f    = ~sclk & q.sclk_p;
  assign ss_f      = ss & ~q.ss_p;
  assign ss_r      = ~ss & q.ss_p;

  always_comb begin
    status          = STAT_RST;
    status[ST_PWR]  = q.pwr != P_OFF;
    status[ST_BUSY] = q.pwr == P_OPER;
    status[ST_MEMF] = q.memf;
    status[ST_SAT]  = q.sat;
    word            = {status, q.press};
    nxt_byte        = q.ibyte[2] ? 8'h00 : word[(5'h3 - 5'(q.ibyte[1:0])) * 5'h8 +: 8];
  end
  always_comb begin
    d            = q;
    fire         = 1'b0;
    d.meas_start = 1'b0;
    d.scl_s      = {q.scl_s[0], lnk.scl};
    d.sda_s      = {q.sda_s[0], lnk.sda};
    d.sclk_s     = {q.sclk_s[0], lnk.sclk};
    d.mosi_s     = {q.mosi_s[0], lnk.mosi};
    d.ss_s       = {q.ss_s[0], lnk.ss_n};
    d.scl_p      = scl;
    d.sda_p      = sda;
    d.sclk_p     = sclk;
    d.ss_p       = ss;
    // i2c slave: bits change only after a falling scl
    if (i2c_start) begin
      d.ist    = I_ADDR;
      d.icnt   = 4'h0;
      d.sda_oe = 1'b0;
      d.cmd_n  = 2'h0;
    end else if (i2c_stop) begin
      fire     = (q.ist == I_WR) && (q.cmd_n == 2'h3) && (q.cmd == CMD_WORD);
      d.ist    = I_IDLE;
      d.sda_oe = 1'b0;
    end else begin
      case (q.ist)
        I_ADDR, I_WR: begin
          if (scl_r) begin
            d.ish  = {q.ish[6:0], sda};
            d.icnt = q.icnt + 4'h1;
          end else if (scl_f && q.icnt == 4'h8) begin
            d.icnt = 4'h0;
            if (q.ist == I_WR && q.cmd_n != 2'h3) begin
              d.cmd   = {q.cmd[15:0], q.ish};
              d.cmd_n = q.cmd_n + 2'h1;
            end
            if (q.ist == I_WR || (q.ish[7:1] == DEV_ADDR && q.pwr != P_OFF)) begin
              d.ist    = (q.ist == I_WR) ? I_ACKW : I_ACKA;
              d.sda_oe = 1'b1;
            end else begin
              d.ist = I_IDLE;
            end
          end
        end
        I_ACKA, I_ACKW: begin
          if (scl_f && q.ist == I_ACKA && q.ish[0]) begin
            d.ist    = I_RD;
            d.ish    = word[31:24];
            d.ibyte  = 3'h1;
            d.sda_oe = ~word[31];
          end else if (scl_f) begin
            d.ist    = I_WR;
            d.sda_oe = 1'b0;
          end
        end
        I_RD: begin
          if (scl_r) begin
            d.icnt = q.icnt + 4'h1;
          end else if (scl_f) begin
            if (q.icnt == 4'h8) begin
              d.ist    = I_ACKR;
              d.icnt   = 4'h0;
              d.sda_oe = 1'b0;
            end else begin
              d.ish    = {q.ish[6:0], 1'b0};
              d.sda_oe = ~q.ish[6];
            end
          end
        end
        I_ACKR: begin
          if (scl_r) begin
            d.iack = ~sda;
          end else if (scl_f) begin
            if (q.iack) begin
              d.ist    = I_RD;
              d.ish    = nxt_byte;
              d.sda_oe = ~nxt_byte[7];
              d.ibyte  = (q.ibyte == 3'h4) ? q.ibyte : q.ibyte + 3'h1;
            end else begin
              d.ist = I_IDLE;
            end
          end
        end
        default: begin
          d.ist    = I_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
    // spi slave, mode 0: shift out on fall, take mosi on rise
    if (ss_f) begin
      d.stx   = (q.pwr != P_OFF) ? word : 32'h0000_0000;
      d.miso  = (q.pwr != P_OFF) & word[31];
      d.sbit  = 3'h0;
      d.cmd_n = 2'h0;
    end else if (ss) begin
      if (sclk_r) begin
        d.sbit = q.sbit + 3'h1;
        if (q.cmd_n != 2'h3) begin
          d.cmd = {q.cmd[22:0], q.mosi_s[1]};
          if (q.sbit == 3'h7) begin
            d.cmd_n = q.cmd_n + 2'h1;
          end
        end
      end else if (sclk_f) begin
        d.stx  = {q.stx[30:0], 1'b0};
        d.miso = q.stx[30];
      end
    end else if (ss_r) begin
      fire   = (q.cmd_n == 2'h3) && (q.cmd == CMD_WORD);
      d.miso = 1'b0;
    end
    // power and measurement sequencing
    case (q.pwr)
      P_OFF: begin
        if (vdd_ok) begin
          d.memf = mem_fail;
          d.pwr  = P_STBY;
        end
      end
      P_STBY: begin
        if (fire) begin
          d.pwr        = P_OPER;
          d.meas_start = 1'b1;
        end
      end
      P_OPER: begin
        if (meas_done) begin
          d.press = meas_word;
          d.sat   = meas_sat;
          d.pwr   = P_STBY;
        end
      end
      default: d.pwr = P_OFF;
    endcase
    if (!vdd_ok) begin
      d.pwr  = P_OFF;
      d.miso = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q       <= '0;
      q.pwr   <= P_OFF;
      q.ist   <= I_IDLE;
      q.press <= PRESS_RST;
      q.scl_s <= SYNC_RST;
      q.sda_s <= SYNC_RST;
      q.ss_s  <= SYNC_RST;
      q.scl_p <= SYNC_RST[0];
      q.sda_p <= SYNC_RST[0];
    end else begin
      q <= d;
    end
  end
  assign lnk.sda_d_o  = 1'b0;
  assign lnk.sda_d_oe = q.sda_oe;
  assign lnk.miso     = q.miso;
  assign meas_start   = q.meas_start;
  assign operating    = q.pwr[2];

endmodule // psr_dev

// >>> include/psr_pkg.sv
package psr_pkg;

  // link constants
  localparam logic [6:0]  DEV_ADDR  = 7'h18;
  localparam logic [7:0]  CMD_MEAS  = 8'haa;
  localparam logic [7:0]  CMD_ARG   = 8'h00;
  localparam logic [7:0]  CMD_NOP   = 8'hf0;
  localparam logic [23:0] CMD_WORD  = {CMD_MEAS, CMD_ARG, CMD_ARG};
  localparam int          RES_BYTES = 4;

  // status byte field positions
  localparam int ST_PWR  = 6;
  localparam int ST_BUSY = 5;
  localparam int ST_MEMF = 2;
  localparam int ST_SAT  = 0;

  // reset values
  localparam logic [23:0] PRESS_RST = 24'h000000;
  localparam logic [7:0]  STAT_RST  = 8'h00;
  localparam logic [1:0]  SYNC_RST  = 2'h3;

  // timing
  localparam int  CLK_MHZ    = 250;
  localparam real T_CMD_MS   = 1.0;
  localparam real T_MEAS_MS  = 2.5;
  localparam int  T_CMD_CYC  = int'(T_CMD_MS * 1000.0 * CLK_MHZ);
  localparam int  T_MEAS_CYC = int'(T_MEAS_MS * 1000.0 * CLK_MHZ);
  localparam int  UP_W       = 20;
  localparam int  QDIV_DEF   = 8;

  // sensor power states
  typedef enum logic [2:0] {
    P_OFF  = 3'h1,
    P_STBY = 3'h2,
    P_OPER = 3'h4
  } psr_pwr_t;

  // i2c slave states
  typedef enum logic [6:0] {
    I_IDLE = 7'h01,
    I_ADDR = 7'h02,
    I_ACKA = 7'h04,
    I_WR   = 7'h08,
    I_ACKW = 7'h10,
    I_RD   = 7'h20,
    I_ACKR = 7'h40
  } psr_i2c_t;

  // host frame states
  typedef enum logic [3:0] {
    H_IDLE  = 4'h1,
    H_START = 4'h2,
    H_BIT   = 4'h4,
    H_STOP  = 4'h8
  } psr_hst_t;

endpackage

// >>> include/psr_link_if.sv
`timescale 1ns/100ps
interface psr_link_if;
  // open-drain i2c pins, resolved here
  logic scl_h_o;
  logic scl_h_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;
  // spi pins
  logic sclk;
  logic mosi;
  logic ss_n;
  logic miso;

  assign scl = ~(scl_h_oe & ~scl_h_o);
  assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);

  modport host (output scl_h_o, scl_h_oe, sda_h_o, sda_h_oe, sclk, mosi, ss_n,
                input scl, sda, miso);
  modport dev  (output sda_d_o, sda_d_oe, miso,
                input scl, sda, sclk, mosi, ss_n);
endinterface

// >>> src/psr_host.sv
`timescale 1ns/100ps
module psr_host
  import psr_pkg::*;
#(
  parameter int QDIV   = QDIV_DEF,
  parameter int T_CMD  = T_CMD_CYC,
  parameter int T_MEAS = T_MEAS_CYC
) (
  // system
  input  wire logic        clk,
  input  wire logic        resetn,
  // link
  psr_link_if.host         lnk,
  // user requests
  input  wire logic        use_spi,
  input  wire logic        cmd_req,
  input  wire logic        rd_req,
  input  wire logic [2:0]  rd_len,
  // user answers
  output logic             ready,
  output logic             cmd_ready,
  output logic             done,
  output logic             nack,
  output logic [31:0]      rd_data
);

  typedef struct packed {
    psr_hst_t    st;
    logic [7:0]  div;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [2:0]  bi;
    logic [2:0]  nb;
    logic        spi;
    logic        rd;
    logic [7:0]  tx;
    logic [31:0] rx;
    logic [1:0]  sda_s;
    logic [1:0]  miso_s;
    logic        scl_oe;
    logic        sda_oe;
    logic        sclk;
    logic        mosi;
    logic        ss_n;
    logic [UP_W-1:0] up;
    logic        ready;
    logic        cmd_ready;
    logic        done;
    logic        nack;
    logic [31:0] rd_data;
  } psr_host_st_t;

  psr_host_st_t q;
  psr_host_st_t d;
  logic         tick;
  logic         rx_byte;
  logic         last_bit;
  logic         smp;
  logic [2:0]   len;

  function automatic logic [7:0] tx_byte(input logic spi, input logic rd, input logic [2:0] i);
    if (spi) begin
      tx_byte = (i != 3'h0) ? CMD_ARG : (rd ? CMD_NOP : CMD_MEAS);
    end else if (i == 3'h0) begin
      tx_byte = {DEV_ADDR, rd};
    end else begin
      tx_byte = rd ? 8'hff : ((i == 3'h1) ? CMD_MEAS : CMD_ARG);
    end
  endfunction

  assign tick     = q.div == 8'(QDIV - 1);
  assign rx_byte  = q.rd & (q.spi | (q.bi != 3'h0));
  assign last_bit = q.spi ? (q.bitn == 4'h7) : (q.bitn == 4'h8);
  assign smp      = q.spi ? q.miso_s[1] : q.sda_s[1];
  assign len      = (rd_len == 3'h0 || rd_len > 3'(RES_BYTES)) ? 3'(RES_BYTES) : rd_len;

  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.sda_s  = {q.sda_s[0], lnk.sda};
    d.miso_s = {q.miso_s[0], lnk.miso};
    if (q.up != UP_W'(T_MEAS)) begin
      d.up = q.up + 1'b1;
    end
    d.div = (q.st == H_IDLE || tick) ? 8'h00 : q.div + 8'h01;
    if (tick) begin
      d.ph = q.ph + 2'h1;
    end
    case (q.st)
      H_IDLE: begin
        d.ph = 2'h0;
        if (q.ready && (rd_req || (cmd_req && q.cmd_ready))) begin
          d.st   = H_START;
          d.spi  = use_spi;
          d.rd   = rd_req;
          d.nb   = rd_req ? (use_spi ? len : len + 3'h1) : (use_spi ? 3'h3 : 3'h4);
          d.tx   = tx_byte(use_spi, rd_req, 3'h0);
          d.bi   = 3'h0;
          d.bitn = 4'h0;
          d.rx   = 32'h0000_0000;
          d.nack = 1'b0;
        end
      end
      H_START: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              d.ss_n   = ~q.spi;
              d.sda_oe = ~q.spi;
            end
            2'h2: d.scl_oe = ~q.spi;
            2'h3: d.st = H_BIT;
            default: d.st = H_START;
          endcase
        end
      end
      H_BIT: begin
        if (tick) begin
          case (q.ph)
            2'h0: begin
              d.mosi = q.tx[7];
              if (!q.spi && q.bitn == 4'h8) begin
                d.sda_oe = rx_byte && (q.bi != q.nb - 3'h1);
              end else begin
                d.sda_oe = ~q.spi & ~q.tx[7];
              end
            end
            2'h1: begin
              d.scl_oe = 1'b0;
              d.sclk   = q.spi;
            end
            2'h2: begin
              if (q.bitn < 4'h8 && rx_byte) begin
                d.rx = {q.rx[30:0], smp};
              end
              if (!q.spi && q.bitn == 4'h8 && !rx_byte && smp) begin
                d.nack = 1'b1;
              end
            end
            default: begin
              d.scl_oe = ~q.spi;
              d.sclk   = 1'b0;
              d.tx     = {q.tx[6:0], 1'b0};
              d.bitn   = q.bitn + 4'h1;
              if (last_bit) begin
                d.bitn = 4'h0;
                if (q.nack || q.bi == q.nb - 3'h1) begin
                  d.st = H_STOP;
                end else begin
                  d.bi = q.bi + 3'h1;
                  d.tx = tx_byte(q.spi, q.rd, q.bi + 3'h1);
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          case (q.ph)
            2'h0: d.sda_oe = ~q.spi;
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              d.sda_oe = 1'b0;
              d.ss_n   = 1'b1;
            end
            default: begin
              d.st      = H_IDLE;
              d.done    = 1'b1;
              d.rd_data = q.rx;
            end
          endcase
        end
      end
      default: d.st = H_IDLE;
    endcase
    d.ready     = (d.st == H_IDLE) && (q.up >= UP_W'(T_CMD));
    d.cmd_ready = d.ready && (q.up == UP_W'(T_MEAS));
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q      <= '0;
      q.st   <= H_IDLE;
      q.ss_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // i2c lines only ever pulled low; spi lines pushed
  assign lnk.scl_h_o  = 1'b0;
  assign lnk.sda_h_o  = 1'b0;
  assign lnk.scl_h_oe = q.scl_oe;
  assign lnk.sda_h_oe = q.sda_oe;
  assign lnk.sclk     = q.sclk;
  assign lnk.mosi     = q.mosi;
  assign lnk.ss_n     = q.ss_n;
  assign ready        = q.ready;
  assign cmd_ready    = q.cmd_ready;
  assign done         = q.done;
  assign nack         = q.nack;
  assign rd_data      = q.rd_data;

endmodule // psr_host

// >>> sim/psr_link_monitor.sv
`timescale 1ns/100ps
module psr_link_monitor (
  // system
  input wire logic clk,
  input wire logic resetn,
  // i2c
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_d_oe,
  // spi
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic miso
);
  typedef struct packed {
    logic       sclk;
    logic       scl;
    logic       sda;
    logic [5:0] sbit;
    logic [5:0] ibit;
    logic       rd;
    logic       ack;
  } psr_mon_t;

  psr_mon_t q;
  psr_mon_t d;

  // bit counters since select or since start/stop
  always_comb begin
    d      = q;
    d.sclk = sclk;
    d.scl  = scl;
    d.sda  = sda;
    if (ss_n) begin
      d.sbit = 6'h0;
    end else if (sclk && !q.sclk) begin
      d.sbit = q.sbit + 6'h1;
    end
    if (scl && q.scl && (q.sda != sda)) begin
      d.ibit = 6'h0;
      d.rd   = 1'b0;
      d.ack  = 1'b0;
    end else if (scl && !q.scl) begin
      d.ibit = q.ibit + 6'h1;
      if (q.ibit == 6'h7) d.rd = sda;
      if (q.ibit == 6'h8) d.ack = !sda;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) q <= '0;
    else q <= d;
  end

  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_SPI_IDLE_LOW: assert property (ss_n |-> !sclk)
    else $error("spi clock high while deselected");
  AST_MISO_RELEASE: assert property (ss_n [*8] |-> !miso)
    else $error("miso driven while deselected");
  AST_MISO_HOLD_HIGH: assert property ($rose(sclk) |=> $stable(miso) [*6])
    else $error("miso changed while spi clock high");
  AST_SPI_RSVD: assert property (sclk && !q.sclk && !ss_n && (q.sbit inside {6'h0, 6'h3, 6'h4, 6'h6}) |-> !miso)
    else $error("reserved status bit nonzero on spi");
  AST_I2C_RSVD: assert property (scl && !q.scl && q.rd && q.ack && (q.ibit inside {6'h9, 6'hc, 6'hd, 6'hf})
                                 |-> sda_d_oe)
    else $error("reserved status bit nonzero on i2c");
  AST_SDA_HOLD_HIGH: assert property (scl && q.scl |-> $stable(sda_d_oe))
    else $error("device data changed while scl high");
  AST_PORT_EXCL: assert property (!ss_n |-> !sda_d_oe && scl)
    else $error("i2c activity during spi frame");
  AST_START_FREE: assert property (scl && q.scl && q.sda && !sda |-> !sda_d_oe)
    else $error("device pulled sda during start");
  AST_SS_HOLD: assert property ($fell(ss_n) |=> !ss_n [*8])
    else $error("select pulse too short");
endmodule // psr_link_monitor

// >>> sim/psr_tb_top.sv
`timescale 1ns/100ps
module psr_tb_top
  import psr_pkg::*;
;
  // system
  logic        clk       = 1'b0;
  logic        resetn    = 1'b0;
  // sensor core
  logic        vdd_ok    = 1'b0;
  logic        mem_fail  = 1'b0;
  logic        meas_done = 1'b0;
  logic [23:0] meas_word = 24'h0;
  logic        meas_sat  = 1'b0;
  logic        meas_start;
  logic        operating;
  // host user side
  logic        use_spi   = 1'b0;
  logic        cmd_req   = 1'b0;
  logic        rd_req    = 1'b0;
  logic [2:0]  rd_len    = 3'h1;
  logic        ready;
  logic        cmd_ready;
  logic        done;
  logic        nack;
  logic [31:0] rd_data;
  int          n_fail    = 0;
  int          checks    = 0;
  int          n_start   = 0;
  int          cyc       = 0;

  psr_link_if lnk ();
  psr_dev psr_dev_inst (.clk(clk), .resetn(resetn), .lnk(lnk), .vdd_ok(vdd_ok), .mem_fail(mem_fail),
    .meas_done(meas_done), .meas_word(meas_word), .meas_sat(meas_sat), .meas_start(meas_start),
    .operating(operating));
  // short start-up waits keep the run brief
  psr_host #(.QDIV(8), .T_CMD(20), .T_MEAS(40)) psr_host_inst (.clk(clk), .resetn(resetn), .lnk(lnk),
    .use_spi(use_spi), .cmd_req(cmd_req), .rd_req(rd_req), .rd_len(rd_len), .ready(ready),
    .cmd_ready(cmd_ready), .done(done), .nack(nack), .rd_data(rd_data));
  psr_link_monitor psr_link_monitor_inst (.clk(clk), .resetn(resetn), .scl(lnk.scl), .sda(lnk.sda),
    .sda_d_oe(lnk.sda_d_oe), .sclk(lnk.sclk), .ss_n(lnk.ss_n), .miso(lnk.miso));

  always #2 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d errors %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (meas_start === 1'b1) n_start <= n_start + 1;
    if (cyc == 60000) begin
      n_fail = n_fail + 1;
      give_verdict();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // let link syncs and the sensor side catch up
  task automatic settle;
    repeat (40) @(posedge clk);
    #1;
  endtask

  task automatic xfer(input logic spi, input logic cmd, input logic [2:0] len);
    int i;
    i = 0;
    while ((cmd ? cmd_ready : ready) !== 1'b1 && i < 9000) begin
      @(posedge clk);
      #1;
      i++;
    end
    @(posedge clk);
    use_spi <= spi;
    rd_len  <= len;
    cmd_req <= cmd;
    rd_req  <= !cmd;
    @(posedge clk);
    cmd_req <= 1'b0;
    rd_req  <= 1'b0;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (done !== 1'b1 && i < 9000);
    chk1(done, 1'b1);
  endtask

  task automatic rd(input logic spi, input logic [2:0] len, input logic [31:0] exp);
    logic [31:0] m;
    m = (len == 3'h4) ? 32'hffffffff : (32'h1 << (32'(len) * 8)) - 32'h1;
    xfer(spi, 1'b0, len);
    chk32(rd_data & m, exp & m);
  endtask

  task automatic cmd(input logic spi, input int starts);
    xfer(spi, 1'b1, 3'h3);
    settle();
    chk1(operating, 1'b1);
    chk32(32'(n_start), 32'(starts));
  endtask

  task automatic power(input logic v, input logic mf);
    @(posedge clk);
    vdd_ok   <= v;
    mem_fail <= mf;
    settle();
  endtask

  task automatic result(input logic [23:0] w, input logic s);
    @(posedge clk);
    meas_word <= w;
    meas_sat  <= s;
    meas_done <= 1'b1;
    @(posedge clk);
    meas_done <= 1'b0;
    settle();
    chk1(operating, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(1'b1, 3'h4, 32'h0);
    xfer(1'b0, 1'b0, 3'h1);
    chk1(nack, 1'b1);
    power(1'b1, 1'b1);
    power(1'b1, 1'b0);
    rd(1'b0, 3'h1, 32'h44);
    chk1(nack, 1'b0);
    cmd(1'b0, 1);
    rd(1'b1, 3'h1, 32'h64);
    cmd(1'b1, 1);
    result(24'hc3a51e, 1'b1);
    rd(1'b1, 3'h4, 32'h45c3a51e);
    rd(1'b0, 3'h4, 32'h45c3a51e);
    cmd(1'b1, 2);
    result(24'h0f1e2d, 1'b0);
    rd(1'b1, 3'h2, 32'h440f);
    rd(1'b0, 3'h3, 32'h440f1e);
    power(1'b0, 1'b0);
    rd(1'b1, 3'h4, 32'h0);
    power(1'b1, 1'b0);
    rd(1'b0, 3'h1, 32'h40);
    give_verdict();
  end
endmodule // psr_tb_top
